// ### dv/adcm_src_model.sv
`timescale 1ns/100ps
// ************************************************************
// analogue sources: each input has a fixed level, compared to dac
// ************************************************************
module adcm_src_model (
  input  wire logic        i_res12,   // 8 bit mode scales level down
  input  wire logic [2:0]  i_in_sel,  // selected conversion_input
  input  wire logic [11:0] i_dac,     // trial code from the engine
  output logic             o_cmp_hi   // input at or above trial
);
  logic [11:0] lvl;  // ratio of input to reference, 12 bit
  // levels differ per source so a wrong mux shows in the result
  assign lvl = 12'h3c5 + 12'(i_in_sel) * 12'h211;
  assign o_cmp_hi = (i_res12 ? lvl : {4'h0, lvl[11:4]}) >= i_dac;
endmodule

// ### dv/adcm_top_assertions.sv
`timescale 1ns/100ps
module adcm_top_checker (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  o_in_sel,
  input wire logic [1:0]  o_refp_sel,
  input wire logic        o_refn_sel,
  input wire logic        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ************************************************************
  // apb steps
  // ************************************************************
  sequence apb_setup; psel && !penable; endsequence
  sequence wr_at(a); psel && penable && pready && pwrite && paddr == a; endsequence
  chk_apb_ready: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  chk_err_access: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  chk_result_width: assert property (pready && paddr == adcm_pkg::ADDR_RESULT
    |-> prdata[31:12] == 20'h0) else $error("result too wide");
  chk_in_range: assert property (o_in_sel <= 3'h4) else $error("bad input");
  chk_refp_range: assert property (o_refp_sel <= 2'h2) else $error("bad refp");
  chk_in_write: assert property ($changed(o_in_sel) |->
    $past(psel && penable && pready && pwrite && paddr == adcm_pkg::ADDR_SEL))
    else $error("input moved alone");
  chk_ref_write: assert property ($changed({o_refp_sel, o_refn_sel})
    |-> $past(psel && penable && pwrite && paddr == adcm_pkg::ADDR_SEL))
    else $error("reference moved alone");
  // flags and irq drop at the very edge that accepts the clear
  chk_irq_clear: assert property ($fell(o_irq) |->
    $past(psel && penable && pready && pwrite && paddr == adcm_pkg::ADDR_STATUS))
    else $error("irq dropped alone");
endmodule
bind adcm_top adcm_top_checker u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .o_in_sel(o_in_sel), .o_refp_sel(o_refp_sel),
  .o_refn_sel(o_refn_sel), .o_irq(o_irq));

// ### dv/adcm_top_bench.sv
`timescale 1ns/100ps
module adcm_top_bench;
  logic i_clk = 0, i_resetn = 0, psel = 0, penable = 0, pwrite = 0, cmp, res12 = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, o_refn_sel, o_irq, err;
  logic [11:0] dac;
  logic [2:0] o_in_sel;
  logic [1:0] o_refp_sel;
  int bad_count = 0, n_compared = 0, cyc = 0;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  adcm_top DUT (.i_clk(i_clk), .i_resetn(i_resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_cmp_hi(cmp), .o_dac_code(dac), .o_in_sel(o_in_sel),
    .o_refp_sel(o_refp_sel), .o_refn_sel(o_refn_sel), .o_irq(o_irq));
  adcm_src_model src (.i_res12(res12), .i_in_sel(o_in_sel), .i_dac(dac), .o_cmp_hi(cmp));
  // ************************************************************
  // bus cycles and comparison
  // ************************************************************
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer; held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    // no cycle count assumed; only the watchdog ends a hung wait
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(0, a, 32'h0);
    cmp32(rd, exp);
  endtask
  // wait for the next rising irq, returns the cycle it was seen
  task automatic irq_rise(output int t);
    int n;
    n = 0;
    while (o_irq === 1'b1 && n < 6000) begin @(posedge i_clk); n++; end
    while (o_irq !== 1'b1 && n < 12000) begin @(posedge i_clk); n++; end
    // an exhausted wait is a failure, not a silent measurement
    if (o_irq !== 1'b1) bad_count++;
    t = cyc;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    cmp32(32'(o_refp_sel), 32'h2);
    rd_chk(adcm_pkg::ADDR_HITHR, 32'hfff);
    rd_chk(adcm_pkg::ADDR_RESULT, 32'h0);
    rd_chk(adcm_pkg::ADDR_SEL, 32'h20);
    // unmapped offset: error flagged with the answer, data reads zero
    xfer(0, 8'h18, 32'h0);
    cmp32({31'h0, err}, 32'h1);
    cmp32(rd, 32'h0);
  endtask
  task automatic t_select;
    for (int i = 0; i < 5; i++) begin
      xfer(1, adcm_pkg::ADDR_SEL, 32'(i) | 32'((i % 3) << 4) | 32'((i & 1) << 8));
      // selects update at the accepting edge; look once they have settled
      @(negedge i_clk);
      cmp32({26'h0, o_refn_sel, o_refp_sel, o_in_sel},
            32'(i) | 32'((i % 3) << 3) | 32'((i & 1) << 5));
    end
  endtask
  task automatic t_convert(input logic r, input logic [2:0] in);
    logic [11:0] lvl;
    lvl = 12'h3c5 + 12'(in) * 12'h211;
    res12 <= r;
    xfer(1, adcm_pkg::ADDR_SEL, 32'(in) | 32'h20);
    xfer(1, adcm_pkg::ADDR_CTRL, {29'h0, r, 2'h1});
    // conversion still running: busy shows, no flag yet
    rd_chk(adcm_pkg::ADDR_STATUS, 32'h8);
    // three cycles per bit through the comparator flops, plus margin
    repeat (50) @(posedge i_clk);
    rd_chk(adcm_pkg::ADDR_RESULT, r ? 32'(lvl) : 32'(lvl[11:4]));
    rd_chk(adcm_pkg::ADDR_STATUS, 32'h1);
    xfer(1, adcm_pkg::ADDR_LOTHR, 32'hfff);
    xfer(1, adcm_pkg::ADDR_CTRL, {29'h0, r, 2'h1});
    repeat (50) @(posedge i_clk);
    cmp32({31'h0, o_irq}, 32'h1);
    rd_chk(adcm_pkg::ADDR_STATUS, 32'h3);
    xfer(1, adcm_pkg::ADDR_LOTHR, 32'h0);
    xfer(1, adcm_pkg::ADDR_STATUS, 32'h7);
    repeat (3) @(posedge i_clk);
    cmp32({31'h0, o_irq}, 32'h0);
  endtask
  task automatic t_rate(input logic r, input int per);
    int t0, t1;
    res12 <= r;
    xfer(1, adcm_pkg::ADDR_HITHR, 32'h0);
    xfer(1, adcm_pkg::ADDR_CTRL, {29'h0, r, 2'h2});
    irq_rise(t0);
    xfer(1, adcm_pkg::ADDR_STATUS, 32'h7);
    irq_rise(t0);
    xfer(1, adcm_pkg::ADDR_STATUS, 32'h7);
    irq_rise(t1);
    cmp32(32'(t1 - t0), 32'(per));
    xfer(1, adcm_pkg::ADDR_CTRL, 32'h0);
    xfer(1, adcm_pkg::ADDR_HITHR, 32'hfff);
    repeat (per + 40) @(posedge i_clk);
    xfer(1, adcm_pkg::ADDR_STATUS, 32'h7);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1;
    t_reset();
    t_select();
    t_convert(1, 3'h4);
    t_convert(0, 3'h2);
    t_rate(0, adcm_pkg::PER8_CYC);
    t_rate(1, adcm_pkg::PER12_CYC);
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    bad_count++;
    end_of_test();
  end
endmodule

// ### logic/adcm_conv_if.sv
`timescale 1ns/100ps
// ************************************************************
// handshake between sequencer and successive approximation engine
// ************************************************************
interface adcm_conv_if;
  logic        start;   // one-cycle pulse, begin a conversion
  logic        res12;   // resolution for this conversion
  logic        done;    // one-cycle pulse, result valid
  logic [11:0] result;  // left in low bits for 8 bit mode
  modport ctl (output start, output res12, input done, input result);
  modport cnv (input start, input res12, output done, output result);
endinterface

// ### logic/adcm_pkg.sv
package adcm_pkg;
  // ************************************************************
  // register map (byte addresses on apb)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // start, mode, resolution
  localparam logic [7:0] ADDR_SEL    = 8'h04; // input and reference selects
  localparam logic [7:0] ADDR_LOTHR  = 8'h08; // lower warning threshold
  localparam logic [7:0] ADDR_HITHR  = 8'h0c; // upper warning threshold
  localparam logic [7:0] ADDR_RESULT = 8'h10; // last result, read only
  localparam logic [7:0] ADDR_STATUS = 8'h14; // sticky flags, write one clear

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_START  = 0; // one-shot start, self clearing
  localparam int CTRL_CONT   = 1; // continuous mode
  localparam int CTRL_RES12  = 2; // 1 = 12 bit, 0 = 8 bit
  localparam int SEL_IN_LSB  = 0; // 3 bit input select
  localparam int SEL_RP_LSB  = 4; // 2 bit positive reference select
  localparam int SEL_RN_BIT  = 8; // negative reference select
  localparam int ST_DONE     = 0; // conversion done
  localparam int ST_LOW      = 1; // below lower threshold
  localparam int ST_HIGH     = 2; // above upper threshold
  localparam int ST_BUSY     = 3; // conversion running (live)

  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [2:0] IN_P3L7 = 3'h0; // port3_line7
  localparam logic [2:0] IN_P3L6 = 3'h1; // port3_line6
  localparam logic [2:0] IN_P3L5 = 3'h2; // port3_line5
  localparam logic [2:0] IN_P3L4 = 3'h3; // port3_line4
  localparam logic [2:0] IN_BG   = 3'h4; // bandgap_source
  localparam logic [1:0] RP_P3L7 = 2'h0; // positive ref on port3_line7
  localparam logic [1:0] RP_BG   = 2'h1; // positive ref on bandgap
  localparam logic [1:0] RP_VDD  = 2'h2; // positive ref on supply
  localparam logic       RN_GND  = 1'b0; // negative ref on ground
  localparam logic       RN_P3L6 = 1'b1; // negative ref on port3_line6

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ      = 50_000_000;
  localparam int RATE8_HZ    = 20_000;
  localparam int RATE12_HZ   = 10_000;
  localparam int PER8_CYC    = CLK_HZ / RATE8_HZ;  // 2500 cycles
  localparam int PER12_CYC   = CLK_HZ / RATE12_HZ; // 5000 cycles
  localparam int IRQ_VECTOR  = 8;  // vector the event is wired to
  localparam int IRQ_PRIO    = 9;  // fixed priority of that vector
  localparam int SYNC_STAGES = 2;  // comparator flops ahead of the engine
  localparam logic [11:0] RESULT_RST = 12'h000;
endpackage

// ### logic/adcm_sar.sv
`timescale 1ns/100ps
// ************************************************************
// successive approximation engine, one bit every three cycles
// ************************************************************
module adcm_sar (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cmp_hi,  // comparator: input above trial level
  output logic      [11:0] o_trial,   // trial code to the dac
  adcm_conv_if.cnv         cv
);
  logic [11:0] code_ff, nxt_code;   // trial register
  logic [3:0]  bit_ff, nxt_bit;     // bit under test
  logic        run_ff, nxt_run;     // conversion running
  logic        done_ff, nxt_done;   // completion pulse
  logic        cmp_s1_ff, cmp_s2_ff; // comparator synchroniser
  logic [1:0]  settle_ff, nxt_settle; // cycles waited for the compare

  // comparator is analogue, so resynchronise it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else begin
      cmp_s1_ff <= i_cmp_hi;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // next state: msb first, keep a bit when the input is above it
  // each trial waits until it has crossed the synchroniser; deciding
  // earlier would judge the bit on the compare of the previous trial
  always_comb begin
    nxt_code   = code_ff;
    nxt_bit    = bit_ff;
    nxt_run    = run_ff;
    nxt_done   = 1'b0;
    nxt_settle = settle_ff;
    if (cv.start && !run_ff) begin
      nxt_run    = 1'b1;
      nxt_bit    = cv.res12 ? 4'hb : 4'h7;
      nxt_code   = cv.res12 ? 12'h800 : 12'h080;
      nxt_settle = 2'h0;
    end else if (run_ff) begin
      if (settle_ff != 2'(adcm_pkg::SYNC_STAGES)) begin
        // trial still travelling through the two flops
        nxt_settle = settle_ff + 2'h1;
      end else begin
        nxt_settle = 2'h0;
        if (!cmp_s2_ff) begin
          nxt_code[bit_ff] = 1'b0;
        end
        if (bit_ff == 4'h0) begin
          nxt_run  = 1'b0;
          nxt_done = 1'b1;
        end else begin
          nxt_bit = bit_ff - 4'h1;
          nxt_code[bit_ff - 4'h1] = 1'b1;
        end
      end
    end
  end

  // register the engine state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      code_ff <= 12'h000;
      bit_ff  <= 4'h0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
      settle_ff <= 2'h0;
    end else begin
      code_ff <= nxt_code;
      bit_ff  <= nxt_bit;
      run_ff  <= nxt_run;
      done_ff <= nxt_done;
      settle_ff <= nxt_settle;
    end
  end

  assign o_trial   = code_ff;
  assign cv.done   = done_ff;
  assign cv.result = code_ff;
endmodule

// ### logic/adcm_top.sv
`timescale 1ns/100ps
// Functional notes
// - one of five inputs per conversion
// - unsigned 8 or 12 bit input ratio result
// - positive reference: line7, bandgap or supply
// - negative reference: line6 or ground
// - continuous rate 20 kHz 8 bit, 10 kHz 12 bit
// - interrupt on below-low or above-high result
// - event goes to vector 8, priority 9
module adcm_top (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_cmp_hi,      // analogue comparator output
  output logic      [11:0] o_dac_code,    // trial level to the dac
  output logic      [2:0]  o_in_sel,      // conversion_input mux select
  output logic      [1:0]  o_refp_sel,    // positive reference mux select
  output logic             o_refn_sel,    // negative reference mux select
  output logic             o_irq          // request on the adc vector
);
  // ************************************************************
  // state
  // ************************************************************
  logic        cont_ff, nxt_cont;        // continuous mode
  logic        res12_ff, nxt_res12;      // resolution select
  logic        start_ff, nxt_start;      // software start request
  logic [2:0]  insel_ff, nxt_insel;      // input source select
  logic [1:0]  rpsel_ff, nxt_rpsel;      // positive reference select
  logic        rnsel_ff, nxt_rnsel;      // negative reference select
  logic [11:0] lothr_ff, nxt_lothr;      // lower warning level
  logic [11:0] hithr_ff, nxt_hithr;      // upper warning level
  logic [11:0] result_ff, nxt_result;    // last completed result
  logic [2:0]  flags_ff, nxt_flags;      // done, low, high sticky
  logic [12:0] tick_ff, nxt_tick;        // sample period counter
  logic        busy_ff, nxt_busy;        // conversion in flight
  logic [31:0] prdata_ff, nxt_prdata;    // read data register
  logic        irq_ff, nxt_irq;          // interrupt output register
  logic        pready_ff, nxt_pready;    // access phase answer
  logic        slverr_ff, nxt_slverr;    // unmapped address answer

  logic        wr_acc;                   // write access phase
  logic        rd_acc;                   // read access phase
  logic        kick;                     // start a conversion now
  logic [12:0] period;                   // cycles for current resolution
  logic [11:0] lo_cmp;                   // threshold at used width
  logic [11:0] hi_cmp;
  logic        mapped;                   // address decodes

  adcm_conv_if cv ();

  adcm_sar u_sar (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_cmp_hi (i_cmp_hi),
    .o_trial  (o_dac_code),
    .cv       (cv.cnv)
  );

  // ************************************************************
  // bus decode and sampling timing
  // ************************************************************
  // access phase answers in zero wait states: pready is registered in
  // setup and rises with penable, so every transfer is two cycles
  assign wr_acc = psel && penable && pwrite && pready_ff;
  assign rd_acc = psel && penable && !pwrite && pready_ff;
  assign mapped = (paddr == adcm_pkg::ADDR_CTRL)  || (paddr == adcm_pkg::ADDR_SEL)    ||
                  (paddr == adcm_pkg::ADDR_LOTHR) || (paddr == adcm_pkg::ADDR_HITHR)  ||
                  (paddr == adcm_pkg::ADDR_RESULT)|| (paddr == adcm_pkg::ADDR_STATUS);
  assign period = res12_ff ? 13'(adcm_pkg::PER12_CYC) : 13'(adcm_pkg::PER8_CYC);
  // in 8 bit mode only the low byte of each level is meaningful
  assign lo_cmp = res12_ff ? lothr_ff : {4'h0, lothr_ff[7:0]};
  assign hi_cmp = res12_ff ? hithr_ff : {4'h0, hithr_ff[7:0]};
  // continuous conversions start on the period tick, else on request
  assign kick   = !busy_ff && ((cont_ff && tick_ff == 13'h0000) || start_ff);
  assign cv.start = kick;
  assign cv.res12 = res12_ff;

  // ************************************************************
  // next values
  // ************************************************************
  always_comb begin
    nxt_cont   = cont_ff;
    nxt_res12  = res12_ff;
    nxt_start  = start_ff;
    nxt_insel  = insel_ff;
    nxt_rpsel  = rpsel_ff;
    nxt_rnsel  = rnsel_ff;
    nxt_lothr  = lothr_ff;
    nxt_hithr  = hithr_ff;
    nxt_result = result_ff;
    nxt_flags  = flags_ff;
    nxt_tick   = tick_ff;
    nxt_busy   = busy_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = psel && !penable;        // ready in the access phase
    nxt_slverr = psel && !penable && !mapped;

    // period counter free runs only in continuous mode
    if (!cont_ff) begin
      nxt_tick = 13'h0000;
    end else if (tick_ff == period - 13'h0001 || tick_ff >= period) begin
      nxt_tick = 13'h0000;
    end else begin
      nxt_tick = tick_ff + 13'h0001;
    end

    if (kick) begin
      nxt_busy  = 1'b1;
      nxt_start = 1'b0;
    end

    // result held until the next completion
    if (cv.done) begin
      nxt_busy   = 1'b0;
      nxt_result = res12_ff ? cv.result : {4'h0, cv.result[7:0]};
    end

    // software clear of sticky flags, write one to clear
    if (wr_acc && paddr == adcm_pkg::ADDR_STATUS) begin
      nxt_flags = flags_ff & ~pwdata[2:0];
    end
    // hardware set wins over a clear in the same cycle
    if (cv.done) begin
      nxt_flags[adcm_pkg::ST_DONE] = 1'b1;
      if (nxt_result < lo_cmp) begin
        nxt_flags[adcm_pkg::ST_LOW] = 1'b1;
      end
      if (nxt_result > hi_cmp) begin
        nxt_flags[adcm_pkg::ST_HIGH] = 1'b1;
      end
    end

    // register writes
    if (wr_acc) begin
      case (paddr)
        adcm_pkg::ADDR_CTRL: begin
          // start_ff here would re-arm a request that kick just consumed
          nxt_start = pwdata[adcm_pkg::CTRL_START] | nxt_start;
          nxt_cont  = pwdata[adcm_pkg::CTRL_CONT];
          nxt_res12 = pwdata[adcm_pkg::CTRL_RES12];
        end
        adcm_pkg::ADDR_SEL: begin
          // out of range input codes fall back to line7
          nxt_insel = (pwdata[adcm_pkg::SEL_IN_LSB +: 3] > adcm_pkg::IN_BG) ?
                      adcm_pkg::IN_P3L7 : pwdata[adcm_pkg::SEL_IN_LSB +: 3];
          nxt_rpsel = (pwdata[adcm_pkg::SEL_RP_LSB +: 2] > adcm_pkg::RP_VDD) ?
                      adcm_pkg::RP_P3L7 : pwdata[adcm_pkg::SEL_RP_LSB +: 2];
          nxt_rnsel = pwdata[adcm_pkg::SEL_RN_BIT];
        end
        adcm_pkg::ADDR_LOTHR: nxt_lothr = pwdata[11:0];
        adcm_pkg::ADDR_HITHR: nxt_hithr = pwdata[11:0];
        default: ;
      endcase
    end

    // read mux, captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        adcm_pkg::ADDR_CTRL:   nxt_prdata = {29'h0, res12_ff, cont_ff, start_ff};
        adcm_pkg::ADDR_SEL:    nxt_prdata = {23'h0, rnsel_ff, 2'h0, rpsel_ff, 1'b0, insel_ff};
        adcm_pkg::ADDR_LOTHR:  nxt_prdata = {20'h0, lothr_ff};
        adcm_pkg::ADDR_HITHR:  nxt_prdata = {20'h0, hithr_ff};
        adcm_pkg::ADDR_RESULT: nxt_prdata = {20'h0, result_ff};
        adcm_pkg::ADDR_STATUS: nxt_prdata = {28'h0, busy_ff, flags_ff};
        default:               nxt_prdata = 32'h0000_0000;
      endcase
    end

    // single level request for the adc vector
    nxt_irq = nxt_flags[adcm_pkg::ST_LOW] | nxt_flags[adcm_pkg::ST_HIGH];
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cont_ff   <= 1'b0;
      res12_ff  <= 1'b0;
      start_ff  <= 1'b0;
      insel_ff  <= adcm_pkg::IN_P3L7;
      rpsel_ff  <= adcm_pkg::RP_VDD;
      rnsel_ff  <= adcm_pkg::RN_GND;
      lothr_ff  <= 12'h000;
      hithr_ff  <= 12'hfff;
      result_ff <= adcm_pkg::RESULT_RST;
      flags_ff  <= 3'h0;
      tick_ff   <= 13'h0000;
      busy_ff   <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      irq_ff    <= 1'b0;
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
    end else begin
      cont_ff   <= nxt_cont;
      res12_ff  <= nxt_res12;
      start_ff  <= nxt_start;
      insel_ff  <= nxt_insel;
      rpsel_ff  <= nxt_rpsel;
      rnsel_ff  <= nxt_rnsel;
      lothr_ff  <= nxt_lothr;
      hithr_ff  <= nxt_hithr;
      result_ff <= nxt_result;
      flags_ff  <= nxt_flags;
      tick_ff   <= nxt_tick;
      busy_ff   <= nxt_busy;
      prdata_ff <= nxt_prdata;
      irq_ff    <= nxt_irq;
      pready_ff <= nxt_pready;
      slverr_ff <= nxt_slverr;
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = slverr_ff;
  assign o_in_sel   = insel_ff;
  assign o_refp_sel = rpsel_ff;
  assign o_refn_sel = rnsel_ff;
  assign o_irq      = irq_ff;
endmodule
